// ---- hw/scrpr_pkg.sv ----
package scrpr_pkg;

    // ************************************************************
    // command codes and command block layout
    // ************************************************************
    localparam int CDB_BYTES = 16;
    localparam int CDB_W = 8 * CDB_BYTES;
    localparam logic [7:0] OP_PREFETCH10 = 8'h34;
    localparam logic [7:0] OP_PREFETCH16 = 8'h90;
    localparam logic [7:0] OP_READ6 = 8'h08;
    localparam int IMMED_BIT = 1;        // bit of byte 1 in both prefetch forms
    localparam int READ6_LBA_HI_W = 5;   // low bits of byte 1 in the 6-byte read
    localparam logic [31:0] READ6_ZERO_COUNT = 32'h0000_0100;

    // ************************************************************
    // reservation service actions
    // ************************************************************
    localparam logic [3:0] SA_REGISTER = 4'h0;
    localparam logic [3:0] SA_RESERVE = 4'h1;
    localparam logic [3:0] SA_RELEASE = 4'h2;
    localparam logic [3:0] SA_PREEMPT_CLR = 4'h5;
    localparam int KEY_W = 64;
    localparam int GEN_W = 32;

    // ************************************************************
    // status and sense answers
    // ************************************************************
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] ST_CONFLICT = 8'h18;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;

    // ************************************************************
    // control states
    // ************************************************************
    typedef enum logic [2:0] {
        SCRPR_IDLE = 3'b000,
        SCRPR_PR_RD = 3'b001,
        SCRPR_PR_EXEC = 3'b010,
        SCRPR_MED_WAIT = 3'b011,
        SCRPR_CLR = 3'b100
    } scrpr_state_t;

endpackage : scrpr_pkg

// ---- hw/scrpr_key_mem.sv ----
// ************************************************************
// registration key store, one word per initiator
// ************************************************************
module scrpr_key_mem #(
    parameter int ADDR_W = 3,
    parameter int DATA_W = 64
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset on the array; the controller sweeps it clear when needed
    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : scrpr_key_mem

// ---- hw/scrpr_core.sv ----
// Functional notes
// - Scope/type used by reserve, release, preempt only
// - Key mismatch for requester gives reservation conflict
// - Register stores service key for requester
// - Preempt-and-clear drops reservation matching service key; here the requester takes it over
// - Persist bit honoured only on register
// - Power restore: clear unless persisted; generation zeroed
// - Generation counts successful register and preempt
// - Opcode 34h: 10-byte prefetch into cache
// - Opcode 90h: 16-byte prefetch, no data out
// - Zero prefetch count fills segment or medium
// - Prefetch status held until operation completes
// - Immediate bit set: check condition, invalid field
// - Opcode 08h: 6-byte read to initiator
// - 6-byte read count zero means 256
// - 6-byte read: no protection info sent/checked
module scrpr_core #(
    parameter int INIT_W = 3
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic power_restore,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [scrpr_pkg::CDB_W-1:0] cmd_cdb,
    input wire logic pr_valid,
    output logic pr_ready,
    input wire logic [INIT_W-1:0] pr_initiator,
    input wire logic [3:0] pr_action,
    input wire logic [7:0] pr_scope_type,
    input wire logic [scrpr_pkg::KEY_W-1:0] pr_key,
    input wire logic [scrpr_pkg::KEY_W-1:0] pr_sa_key,
    input wire logic pr_aptpl,
    output logic med_req,
    output logic [63:0] med_lba,
    output logic [31:0] med_count,
    output logic med_to_cache,
    output logic med_fill,
    output logic med_pi_xfer,
    output logic med_pi_check,
    input wire logic med_done,
    output logic status_valid,
    output logic [7:0] status_code,
    output logic [3:0] sense_key,
    output logic [7:0] sense_asc,
    output logic res_valid,
    output logic [INIT_W-1:0] res_holder,
    output logic [7:0] res_scope_type,
    output logic aptpl,
    output logic [scrpr_pkg::GEN_W-1:0] generation
);

    // ************************************************************
    // helpers and declarations
    // ************************************************************
    function automatic logic [7:0] cdb_byte(input logic [scrpr_pkg::CDB_W-1:0] c, input int i);
        return c[scrpr_pkg::CDB_W-1-8*i -: 8];
    endfunction : cdb_byte

    scrpr_pkg::scrpr_state_t state;
    logic [INIT_W-1:0] clr_idx;
    logic [INIT_W-1:0] init_q;
    logic [3:0] act_q;
    logic [7:0] st_q;
    logic [scrpr_pkg::KEY_W-1:0] key_q;
    logic [scrpr_pkg::KEY_W-1:0] sa_key_q;
    logic aptpl_q;
    logic [scrpr_pkg::KEY_W-1:0] res_key;
    logic [scrpr_pkg::KEY_W-1:0] key_rdata;
    logic cmd_fire;
    logic pr_fire;
    logic [7:0] opcode;
    logic [7:0] cdb_b1;
    logic is_pf10;
    logic is_pf16;
    logic is_rd6;
    logic pf_immed;
    logic act_known;
    logic key_ok;
    logic rsv_busy;
    logic exec_ok;
    logic in_exec;
    logic mem_we;

    // ************************************************************
    // command acceptance and decode
    // ************************************************************
    // a command block wins over a reservation request in the same cycle
    assign cmd_ready = (state == scrpr_pkg::SCRPR_IDLE) && !power_restore;
    assign pr_ready = cmd_ready && !cmd_valid;
    assign cmd_fire = cmd_valid && cmd_ready;
    assign pr_fire = pr_valid && pr_ready;

    // byte 0 is looked at before any other field is trusted
    assign opcode = cdb_byte(cmd_cdb, 0);
    assign is_pf10 = (opcode == scrpr_pkg::OP_PREFETCH10);
    assign is_pf16 = (opcode == scrpr_pkg::OP_PREFETCH16);
    assign is_rd6 = (opcode == scrpr_pkg::OP_READ6);
    assign cdb_b1 = cdb_byte(cmd_cdb, 1);
    assign pf_immed = cdb_b1[scrpr_pkg::IMMED_BIT];

    // ************************************************************
    // reservation checks, valid in the execute state
    // ************************************************************
    assign in_exec = (state == scrpr_pkg::SCRPR_PR_EXEC);
    assign act_known = (act_q == scrpr_pkg::SA_REGISTER) || (act_q == scrpr_pkg::SA_RESERVE)
        || (act_q == scrpr_pkg::SA_RELEASE) || (act_q == scrpr_pkg::SA_PREEMPT_CLR);
    // an unregistered initiator holds key zero, so it must also present zero
    assign key_ok = (key_q == key_rdata);
    assign rsv_busy = (act_q == scrpr_pkg::SA_RESERVE) && res_valid && (res_holder != init_q);
    assign exec_ok = in_exec && act_known && key_ok && !rsv_busy;

    // ************************************************************
    // key store and its write port
    // ************************************************************
    assign mem_we = (state == scrpr_pkg::SCRPR_CLR)
        || (exec_ok && (act_q == scrpr_pkg::SA_REGISTER));

    scrpr_key_mem #(
        .ADDR_W(INIT_W),
        .DATA_W(scrpr_pkg::KEY_W)
    ) u_keys (
        .mclk(mclk),
        .we(mem_we),
        .waddr((state == scrpr_pkg::SCRPR_CLR) ? clr_idx : init_q),
        .wdata((state == scrpr_pkg::SCRPR_CLR) ? {scrpr_pkg::KEY_W{1'b0}} : sa_key_q),
        .raddr(init_q), // held copy, so the word read still belongs to the requester
        .rdata(key_rdata)
    );

    // ************************************************************
    // control sequence
    // ************************************************************
    // power restore aborts whatever runs; a non-persisted state sweeps all keys
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= scrpr_pkg::SCRPR_IDLE;
            clr_idx <= '0;
        end
        else if (power_restore)
        begin
            state <= aptpl ? scrpr_pkg::SCRPR_IDLE : scrpr_pkg::SCRPR_CLR;
            clr_idx <= '0;
        end
        else
        begin
            case (state)
                scrpr_pkg::SCRPR_IDLE:
                begin
                    if (cmd_fire && ((is_pf10 || is_pf16) && !pf_immed || is_rd6))
                    begin
                        state <= scrpr_pkg::SCRPR_MED_WAIT;
                    end
                    else if (pr_fire)
                    begin
                        state <= scrpr_pkg::SCRPR_PR_RD;
                    end
                end
                scrpr_pkg::SCRPR_PR_RD: state <= scrpr_pkg::SCRPR_PR_EXEC;
                scrpr_pkg::SCRPR_PR_EXEC: state <= scrpr_pkg::SCRPR_IDLE;
                scrpr_pkg::SCRPR_MED_WAIT:
                begin
                    if (med_done)
                    begin
                        state <= scrpr_pkg::SCRPR_IDLE;
                    end
                end
                scrpr_pkg::SCRPR_CLR:
                begin
                    clr_idx <= clr_idx + 1'b1;
                    if (&clr_idx)
                    begin
                        state <= scrpr_pkg::SCRPR_IDLE;
                    end
                end
                default: state <= scrpr_pkg::SCRPR_IDLE;
            endcase
        end
    end

    // request fields held through the read of the key store
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            init_q <= '0;
            act_q <= '0;
            st_q <= '0;
            key_q <= '0;
            sa_key_q <= '0;
            aptpl_q <= 1'b0;
        end
        else if (pr_fire)
        begin
            init_q <= pr_initiator;
            act_q <= pr_action;
            st_q <= pr_scope_type;
            key_q <= pr_key;
            sa_key_q <= pr_sa_key;
            aptpl_q <= pr_aptpl;
        end
    end

    // ************************************************************
    // reservation state, persist bit and generation
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            res_valid <= 1'b0;
            res_holder <= '0;
            res_scope_type <= '0;
            res_key <= '0;
        end
        else if (power_restore)
        begin
            if (!aptpl)
            begin
                res_valid <= 1'b0;
            end
        end
        else if (exec_ok)
        begin
            case (act_q)
                scrpr_pkg::SA_RESERVE:
                begin
                    res_valid <= 1'b1;
                    res_holder <= init_q;
                    res_scope_type <= st_q;
                    res_key <= key_q;
                end
                scrpr_pkg::SA_RELEASE:
                begin
                    if (res_valid && (res_holder == init_q) && (res_scope_type == st_q))
                    begin
                        res_valid <= 1'b0;
                    end
                end
                scrpr_pkg::SA_PREEMPT_CLR:
                begin
                    // requester takes over the reservation it preempts
                    if (res_valid && (res_key == sa_key_q))
                    begin
                        res_holder <= init_q;
                        res_scope_type <= st_q;
                        res_key <= key_q;
                    end
                end
                default: res_valid <= res_valid; // register leaves scope and type alone
            endcase
        end
    end

    // persist bit only follows a successful register
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aptpl <= 1'b0;
        end
        else if (exec_ok && (act_q == scrpr_pkg::SA_REGISTER))
        begin
            aptpl <= aptpl_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            generation <= '0;
        end
        else if (power_restore)
        begin
            generation <= '0;
        end
        else if (exec_ok && ((act_q == scrpr_pkg::SA_REGISTER) || (act_q == scrpr_pkg::SA_PREEMPT_CLR)))
        begin
            generation <= generation + 1'b1;
        end
    end

    // ************************************************************
    // medium request
    // ************************************************************
    // protection information is never moved or checked on these commands
    assign med_pi_xfer = 1'b0;
    assign med_pi_check = 1'b0;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            med_req <= 1'b0;
            med_lba <= '0;
            med_count <= '0;
            med_to_cache <= 1'b0;
            med_fill <= 1'b0;
        end
        else
        begin
            med_req <= 1'b0;
            if (cmd_fire && (is_pf10 || is_pf16) && !pf_immed)
            begin
                med_req <= 1'b1;
                med_to_cache <= 1'b1;
                if (is_pf10)
                begin
                    med_lba <= {32'h0000_0000, cdb_byte(cmd_cdb, 2), cdb_byte(cmd_cdb, 3),
                        cdb_byte(cmd_cdb, 4), cdb_byte(cmd_cdb, 5)};
                    med_count <= {16'h0000, cdb_byte(cmd_cdb, 7), cdb_byte(cmd_cdb, 8)};
                    med_fill <= ({cdb_byte(cmd_cdb, 7), cdb_byte(cmd_cdb, 8)} == 16'h0000);
                end
                else
                begin
                    med_lba <= {cdb_byte(cmd_cdb, 2), cdb_byte(cmd_cdb, 3), cdb_byte(cmd_cdb, 4),
                        cdb_byte(cmd_cdb, 5), cdb_byte(cmd_cdb, 6), cdb_byte(cmd_cdb, 7),
                        cdb_byte(cmd_cdb, 8), cdb_byte(cmd_cdb, 9)};
                    med_count <= {cdb_byte(cmd_cdb, 10), cdb_byte(cmd_cdb, 11),
                        cdb_byte(cmd_cdb, 12), cdb_byte(cmd_cdb, 13)};
                    med_fill <= ({cdb_byte(cmd_cdb, 10), cdb_byte(cmd_cdb, 11),
                        cdb_byte(cmd_cdb, 12), cdb_byte(cmd_cdb, 13)} == 32'h0000_0000);
                end
            end
            else if (cmd_fire && is_rd6)
            begin
                med_req <= 1'b1;
                med_to_cache <= 1'b0;
                med_fill <= 1'b0;
                med_lba <= {43'h0, cdb_b1[scrpr_pkg::READ6_LBA_HI_W-1:0],
                    cdb_byte(cmd_cdb, 2), cdb_byte(cmd_cdb, 3)};
                med_count <= (cdb_byte(cmd_cdb, 4) == 8'h00) ? scrpr_pkg::READ6_ZERO_COUNT
                    : {24'h00_0000, cdb_byte(cmd_cdb, 4)};
            end
        end
    end

    // ************************************************************
    // completion status
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_valid <= 1'b0;
            status_code <= scrpr_pkg::ST_GOOD;
            sense_key <= scrpr_pkg::SK_NONE;
            sense_asc <= scrpr_pkg::ASC_NONE;
        end
        else
        begin
            status_valid <= 1'b0;
            if (cmd_fire && (is_pf10 || is_pf16) && pf_immed)
            begin
                status_valid <= 1'b1;
                status_code <= scrpr_pkg::ST_CHECK;
                sense_key <= scrpr_pkg::SK_ILLEGAL;
                sense_asc <= scrpr_pkg::ASC_BAD_FIELD;
            end
            else if (cmd_fire && !(is_pf10 || is_pf16 || is_rd6))
            begin
                status_valid <= 1'b1;
                status_code <= scrpr_pkg::ST_CHECK;
                sense_key <= scrpr_pkg::SK_ILLEGAL;
                sense_asc <= scrpr_pkg::ASC_BAD_OPCODE;
            end
            else if ((state == scrpr_pkg::SCRPR_MED_WAIT) && med_done && !power_restore)
            begin
                status_valid <= 1'b1;
                status_code <= scrpr_pkg::ST_GOOD;
                sense_key <= scrpr_pkg::SK_NONE;
                sense_asc <= scrpr_pkg::ASC_NONE;
            end
            else if (in_exec && !power_restore)
            begin
                status_valid <= 1'b1;
                status_code <= !act_known ? scrpr_pkg::ST_CHECK
                    : (exec_ok ? scrpr_pkg::ST_GOOD : scrpr_pkg::ST_CONFLICT);
                sense_key <= act_known ? scrpr_pkg::SK_NONE : scrpr_pkg::SK_ILLEGAL;
                sense_asc <= act_known ? scrpr_pkg::ASC_NONE : scrpr_pkg::ASC_BAD_FIELD;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_immed_check;
        @(posedge mclk) disable iff (!rst_b)
        cmd_fire && (is_pf10 || is_pf16) && pf_immed |=> status_valid && status_code == 8'h02
            && sense_key == 4'h5 && sense_asc == 8'h24 && !med_req;
    endproperty
    a_immed_check: assert property (p_immed_check) else $error("immediate prefetch not refused");

    property p_prefetch_cache;
        @(posedge mclk) disable iff (!rst_b)
        cmd_fire && (is_pf10 || is_pf16) && !pf_immed |=> med_req && med_to_cache && !status_valid;
    endproperty
    a_prefetch_cache: assert property (p_prefetch_cache) else $error("prefetch not sent to cache");

    property p_pf16_fields;
        @(posedge mclk) disable iff (!rst_b)
        cmd_fire && is_pf16 && !pf_immed |=> med_lba == $past(cmd_cdb[111:48])
            && med_count == $past(cmd_cdb[47:16]);
    endproperty
    a_pf16_fields: assert property (p_pf16_fields) else $error("16-byte prefetch fields wrong");

    property p_read6_zero;
        @(posedge mclk) disable iff (!rst_b)
        cmd_fire && is_rd6 && cmd_cdb[95:88] == 8'h00 |=> med_req && med_count == 32'h0000_0100 && !med_to_cache;
    endproperty
    a_read6_zero: assert property (p_read6_zero) else $error("zero read count not 256");

    property p_no_pi;
        @(posedge mclk) disable iff (!rst_b)
        med_req |-> !med_pi_xfer && !med_pi_check;
    endproperty
    a_no_pi: assert property (p_no_pi) else $error("protection info used on read");

    property p_hold_status;
        @(posedge mclk) disable iff (!rst_b)
        state == scrpr_pkg::SCRPR_MED_WAIT && !med_done |=> !status_valid;
    endproperty
    a_hold_status: assert property (p_hold_status) else $error("status before completion");

    property p_gen_step;
        @(posedge mclk) disable iff (!rst_b)
        generation != $past(generation) |-> generation == $past(generation) + 1'b1 || generation == '0;
    endproperty
    a_gen_step: assert property (p_gen_step) else $error("generation jumped");

    property p_power_clear;
        @(posedge mclk) disable iff (!rst_b)
        power_restore && !aptpl |=> generation == '0 && !res_valid ##8 state != scrpr_pkg::SCRPR_CLR;
    endproperty
    a_power_clear: assert property (p_power_clear) else $error("power restore not cleared");

    property p_conflict;
        @(posedge mclk) disable iff (!rst_b)
        in_exec && act_known && !key_ok |=> status_valid && status_code == 8'h18 && $stable(generation);
    endproperty
    a_conflict: assert property (p_conflict) else $error("key mismatch not a conflict");

    property p_bad_opcode;
        @(posedge mclk) disable iff (!rst_b)
        cmd_fire && !(is_pf10 || is_pf16 || is_rd6) |=> status_valid && sense_asc == 8'h20 && !med_req;
    endproperty
    a_bad_opcode: assert property (p_bad_opcode) else $error("unknown opcode accepted");

    c_prefetch_done: cover property (@(posedge mclk) disable iff (!rst_b)
        med_req && med_to_cache ##[1:20] status_valid);
    c_register_ok: cover property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && act_q == scrpr_pkg::SA_REGISTER);
    c_preempt_ok: cover property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && act_q == scrpr_pkg::SA_PREEMPT_CLR && res_valid && res_key == sa_key_q);
    c_power_sweep: cover property (@(posedge mclk) disable iff (!rst_b)
        state == scrpr_pkg::SCRPR_CLR);

endmodule : scrpr_core

// ---- sim/scrpr_medium.sv ----
// a medium that is busy for LAT cycles per request
module scrpr_medium #(
    parameter int LAT = 5
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic med_req,
    output logic med_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // slow answer, so status held back until done is visible
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 0;
            med_done <= 1'b0;
        end
        else
        begin
            med_done <= (cnt == 1);
            cnt <= med_req ? LAT : (cnt != 0 ? cnt - 1 : 0);
        end
    end
endmodule : scrpr_medium

// ---- sim/scrpr_core_bench.sv ----
module scrpr_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LAT = 5;
    logic mclk = 0, rst_b = 0, power_restore = 0, cmd_valid = 0, pr_valid = 0, pr_aptpl = 0;
    logic [127:0] cmd_cdb = '0;
    logic [2:0] pr_initiator = '0;
    logic [3:0] pr_action = '0;
    logic [7:0] pr_scope_type = '0;
    logic [63:0] pr_key = '0, pr_sa_key = '0;
    logic cmd_ready, pr_ready, med_req, med_to_cache, med_fill, med_pi_xfer, med_pi_check, med_done;
    logic status_valid, res_valid, aptpl;
    logic [63:0] med_lba;
    logic [31:0] med_count, generation;
    logic [7:0] status_code, sense_asc, res_scope_type;
    logic [3:0] sense_key;
    logic [2:0] res_holder;
    int fails = 0, checks = 0;
    scrpr_core DUT (.mclk(mclk), .rst_b(rst_b), .power_restore(power_restore), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_cdb(cmd_cdb), .pr_valid(pr_valid), .pr_ready(pr_ready),
        .pr_initiator(pr_initiator), .pr_action(pr_action), .pr_scope_type(pr_scope_type), .pr_key(pr_key),
        .pr_sa_key(pr_sa_key), .pr_aptpl(pr_aptpl), .med_req(med_req), .med_lba(med_lba), .med_count(med_count),
        .med_to_cache(med_to_cache), .med_fill(med_fill), .med_pi_xfer(med_pi_xfer), .med_pi_check(med_pi_check),
        .med_done(med_done), .status_valid(status_valid), .status_code(status_code), .sense_key(sense_key),
        .sense_asc(sense_asc), .res_valid(res_valid), .res_holder(res_holder), .res_scope_type(res_scope_type),
        .aptpl(aptpl), .generation(generation));
    scrpr_medium #(.LAT(LAT)) MED (.mclk(mclk), .rst_b(rst_b), .med_req(med_req), .med_done(med_done));
    initial forever #25 mclk = ~mclk;
    task chk(input string n, input logic [127:0] s, e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // bounded wait for the next pulse from the core
    task wt(output int n);
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 40)
            begin
                fails++;
                stop_test;
            end
        end while (!(med_req || status_valid));
    endtask : wt
    task run_cmd(input logic [127:0] c, input logic m, input logic [7:0] st);
        int n;
        cmd_valid = 1;
        cmd_cdb = c;
        chk("cmd_ready", cmd_ready, 1);
        @(posedge mclk);
        #1;
        cmd_valid = 0;
        // request and refusal both appear just after the taking edge itself
        chk("med_req", med_req, m);
        if (m) wt(n);
        if (m) chk("done_wait", n > LAT, 1);
        chk("status", {status_valid, status_code}, {1'b1, st});
        // let an edge pass so the next call never re-raises valid in this time step
        @(posedge mclk);
        #1;
    endtask : run_cmd
    task run_pr(input logic [2:0] i, input logic [3:0] a, input logic [63:0] k, s, input logic [7:0] sc, st);
        {pr_valid, pr_initiator, pr_action, pr_key, pr_sa_key, pr_scope_type} = {1'b1, i, a, k, s, sc};
        chk("pr_ready", pr_ready, 1);
        @(posedge mclk);
        #1;
        pr_valid = 0;
        // status is launched by the second edge after the taking edge
        repeat (2) @(posedge mclk);
        #1;
        chk("pr_status", {status_valid, status_code}, {1'b1, st});
    endtask : run_pr
    task pwr;
        power_restore = 1;
        @(posedge mclk);
        #1;
        power_restore = 0;
        repeat (12) @(posedge mclk);
        #1;
    endtask : pwr
    // ************************************************************
    // scenarios
    // ************************************************************
    task t_prefetch;
        run_cmd({8'h34, 8'h00, 32'h01020304, 8'h00, 16'h0506, 56'h0}, 1, 8'h00);
        chk("pf10", {med_lba, med_count, med_to_cache, med_fill}, {64'h01020304, 32'h506, 2'b10});
        run_cmd({8'h34, 8'h00, 32'h00000009, 8'h00, 16'h0000, 56'h0}, 1, 8'h00);
        chk("fill", med_fill, 1);
        run_cmd({8'h90, 8'h00, 64'h0123456789ABCDEF, 32'h00000007, 16'h0}, 1, 8'h00);
        chk("pf16", {med_lba, med_count, med_to_cache, med_fill}, {64'h0123456789ABCDEF, 32'h7, 2'b10});
    endtask : t_prefetch
    task t_refuse;
        run_cmd({8'h34, 8'h02, 112'h0}, 0, 8'h02);
        chk("immed10", {sense_key, sense_asc}, 12'h524);
        run_cmd({8'h90, 8'h02, 112'h0}, 0, 8'h02);
        chk("immed16", {sense_key, sense_asc}, 12'h524);
        run_cmd({8'hFF, 120'h0}, 0, 8'h02);
        chk("badop", {sense_key, sense_asc}, 12'h520);
    endtask : t_refuse
    task t_read6;
        run_cmd({8'h08, 8'hFF, 8'hAB, 8'hCD, 8'h00, 88'h0}, 1, 8'h00);
        chk("rd6", {med_lba, med_to_cache}, {64'h001FABCD, 1'b0});
        chk("rd6_cnt", med_count, 32'h100);
        chk("rd6_pi", {med_pi_xfer, med_pi_check}, 0);
    endtask : t_read6
    task t_reserve;
        pr_aptpl = 1;
        run_pr(0, 4'h0, 0, 64'hA5, 8'h77, 8'h00);
        chk("gen_reg", {generation, aptpl}, {32'h1, 1'b1});
        pr_aptpl = 0;
        run_pr(1, 4'h1, 64'hA5, 0, 8'h13, 8'h18);
        run_pr(0, 4'h1, 64'hA5, 0, 8'h13, 8'h00);
        chk("rsv", {res_valid, res_holder, res_scope_type, aptpl}, {1'b1, 3'h0, 8'h13, 1'b1});
        chk("gen_rsv", generation, 1);
        pr_aptpl = 1;
        run_pr(1, 4'h0, 0, 64'h5A, 8'hFF, 8'h00);
        pr_aptpl = 0; // preempt below must not touch the persist bit
        chk("scope_kept", res_scope_type, 8'h13);
        run_pr(1, 4'h5, 64'h5A, 64'hA5, 8'h21, 8'h00);
        chk("preempt", {res_holder, res_scope_type, generation}, {3'h1, 8'h21, 32'h3});
        pwr;
        chk("keep", {res_valid, generation}, {1'b1, 32'h0});
        run_pr(1, 4'h0, 64'h5A, 64'h5A, 8'h00, 8'h00);
        pwr;
        chk("drop", {res_valid, generation}, 0);
        run_pr(1, 4'h1, 0, 0, 8'h13, 8'h00);
    endtask : t_reserve
    initial
    begin
        repeat (6) @(posedge mclk);
        #1;
        rst_b = 1;
        pwr;
        t_prefetch;
        t_refuse;
        t_read6;
        t_reserve;
        stop_test;
    end
endmodule : scrpr_core_bench
